// File: rtl/addr_sel_params.svh
// Constants for the two-wire target address selection block.
`ifndef ADDR_SEL_PARAMS_SVH
`define ADDR_SEL_PARAMS_SVH

`define ADDR_BASE        7'h50
`define ADDR_BCAST       7'h58
`define SEL_CODE_W       8
// Sensed level is an 8-bit code; each of the eight bands is 32 codes wide.
`define SEL_BAND_SHIFT   5
// Codes within this distance of an edge between two bands raise the warning flag.
`define SEL_GUARD        5'h0_004
`define STATUS_ADDR_BIT  5
`define CLK_MHZ          50
`define TLOW_MIN_US      650
`define TLOW_MAX_US      1300
// Both limits are exact cycle counts with no rounding; stuck-low limit sits midway between.
`define TLOW_MIN_CYC     ((`TLOW_MIN_US * `CLK_MHZ))
`define TLOW_MAX_CYC     ((`TLOW_MAX_US * `CLK_MHZ))
`define TLOW_CYC         ((`TLOW_MIN_CYC + `TLOW_MAX_CYC) / 2)

`endif

// File: rtl/addr_sel_pkg.sv
// Types shared by the address selection block.
package addr_sel_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_DATA = 3'b011,
    ST_DACK = 3'b100,
    ST_SKIP = 3'b101
  } link_state_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       warn;
  } sel_decode_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       bcast;
    logic [7:0] data;
  } wr_byte_t;

endpackage

// File: rtl/i2c_target_addr.sv
// Two-wire target front end with pin-selected and broadcast addresses.
`timescale 1ns/1ns
`include "addr_sel_params.svh"

// Function
// - Acts only as target, controller clocks.
// - Address from select pin, 0x50 to 0x57.
// - Address rises by one per band.
// - Near an edge between two bands sets warning status bit.
// - Also accept broadcast address 0x58 for writes.
// - Seven address bits MSB first, then direction.
// - Drive data low through ninth pulse on match.
// - Data stuck low resets the interface.
// - First written byte is the register pointer.
module i2c_target_addr #(
  parameter int unsigned TLOW_CYCLES = `TLOW_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] sel_code_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [6:0]      own_addr_o,
  output logic [7:0]      status_o,
  output logic            wr_valid_o,
  output logic            wr_first_o,
  output logic            wr_bcast_o,
  output logic [7:0]      wr_data_o,
  output logic            timeout_o
);

  function automatic addr_sel_pkg::sel_decode_t decode_sel(input logic [7:0] code);
    addr_sel_pkg::sel_decode_t d;
    logic [4:0] pos;
    d      = '0;
    pos    = code[4:0];
    d.addr = `ADDR_BASE + {4'h0, code[7:5]};
    d.warn = (pos < `SEL_GUARD && code[7:5] != 3'h0) ||
             (pos > (5'h1F - `SEL_GUARD) && code[7:5] != 3'h7);
    return d;
  endfunction

  typedef struct packed {
    addr_sel_pkg::link_state_t state;
    logic [3:0]                bitcnt;
    logic [7:0]                shreg;
    logic                      scl_d;
    logic                      sda_d;
    logic                      drive_low;
    logic                      first;
    logic                      bcast;
    logic                      rd;
    logic [6:0]                addr;
    logic                      warn;
    logic                      latched;
    logic [16:0]               lowcnt;
    logic                      tmo;
    addr_sel_pkg::wr_byte_t    wr;
  } core_t;

  core_t st;
  core_t next_st;
  logic  scl_s;
  logic  sda_s;
  addr_sel_pkg::sel_decode_t dec;

  pin_sync u_sync_scl (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (scl_i),
    .level_o   (scl_s)
  );

  pin_sync u_sync_sda (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (sda_i),
    .level_o   (sda_s)
  );

  assign dec = decode_sel(sel_code_i);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] byte_in;
    scl_rise = scl_s && !st.scl_d;
    scl_fall = !scl_s && st.scl_d;
    start    = scl_s && st.scl_d && st.sda_d && !sda_s;
    stop     = scl_s && st.scl_d && !st.sda_d && sda_s;
    byte_in  = {st.shreg[6:0], sda_s};
    next_st          = st;
    next_st.scl_d    = scl_s;
    next_st.sda_d    = sda_s;
    next_st.wr.valid = 1'b0;
    next_st.tmo      = 1'b0;
    // The address is caught once after reset so a noisy select level cannot move it mid-frame.
    if (!st.latched) begin
      next_st.addr    = dec.addr;
      next_st.warn    = dec.warn;
      next_st.latched = 1'b1;
    end
    if (sda_s) begin
      next_st.lowcnt = '0;
    end else if (st.lowcnt != 17'(TLOW_CYCLES)) begin
      next_st.lowcnt = st.lowcnt + 17'h0_0001;
    end
    // Own ack drive is excluded so the stuck-low watch never fires while this target drives data low.
    if (st.lowcnt == 17'(TLOW_CYCLES) - 17'h0_0001 && !st.drive_low) begin
      next_st.state     = addr_sel_pkg::ST_IDLE;
      next_st.drive_low = 1'b0;
      next_st.tmo       = 1'b1;
    end else if (start) begin
      next_st.state     = addr_sel_pkg::ST_ADDR;
      next_st.bitcnt    = 4'h0;
      next_st.drive_low = 1'b0;
    end else if (stop) begin
      next_st.state     = addr_sel_pkg::ST_IDLE;
      next_st.drive_low = 1'b0;
    end else begin
      case (st.state)
        addr_sel_pkg::ST_ADDR, addr_sel_pkg::ST_DATA: begin
          if (scl_rise) begin
            next_st.shreg  = byte_in;
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            if (st.state == addr_sel_pkg::ST_ADDR) begin
              next_st.rd    = st.shreg[0];
              next_st.bcast = st.shreg[7:1] == `ADDR_BCAST;
              if ((st.shreg[7:1] == st.addr) ||
                  (st.shreg[7:1] == `ADDR_BCAST && !st.shreg[0])) begin
                next_st.state     = addr_sel_pkg::ST_ACK;
                next_st.drive_low = 1'b1;
                next_st.first     = 1'b1;
              end else begin
                next_st.state = addr_sel_pkg::ST_SKIP;
              end
            end else begin
              next_st.state     = addr_sel_pkg::ST_DACK;
              next_st.drive_low = 1'b1;
              next_st.wr.valid  = 1'b1;
              next_st.wr.data   = st.shreg;
              next_st.wr.first  = st.first;
              next_st.wr.bcast  = st.bcast;
              next_st.first     = 1'b0;
            end
          end
        end
        addr_sel_pkg::ST_ACK, addr_sel_pkg::ST_DACK: begin
          if (scl_fall) begin
            next_st.drive_low = 1'b0;
            // Reads are not served: after the address ack a read goes to ST_SKIP.
            next_st.state = st.rd ? addr_sel_pkg::ST_SKIP : addr_sel_pkg::ST_DATA;
          end
        end
        default: begin
          next_st.state = st.state;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '{state: addr_sel_pkg::ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign sda_o      = 1'b0;
  assign sda_oe_o   = st.drive_low;
  assign own_addr_o = st.addr;
  assign status_o   = {2'b00, st.warn, 5'b0_0000};
  assign wr_valid_o = st.wr.valid;
  assign wr_first_o = st.wr.first;
  assign wr_bcast_o = st.wr.bcast;
  assign wr_data_o  = st.wr.data;
  assign timeout_o  = st.tmo;

  ////////////////////////////////////////////////////////////////////////////

  AST_ACK_HELD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.state == addr_sel_pkg::ST_ACK |-> sda_oe_o) else $error("ack released early");
  AST_NO_BCAST_READ: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.state == addr_sel_pkg::ST_ACK |-> !(st.bcast && st.rd))
    else $error("broadcast read acknowledged");
  AST_ADDR_RANGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.latched |-> (own_addr_o >= `ADDR_BASE && own_addr_o <= 7'h57))
    else $error("own address out of range");
  AST_ADDR_STABLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $past(st.latched) |-> $stable(own_addr_o)) else $error("own address moved");
  AST_WARN_BIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    status_o[`STATUS_ADDR_BIT] == st.warn && status_o[4:0] == 5'h0_0000)
    else $error("warning bit misplaced");
  AST_TMO_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    timeout_o |-> st.state == addr_sel_pkg::ST_IDLE && !sda_oe_o)
    else $error("timeout left link busy");
  AST_FIRST_ONCE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_valid_o && wr_first_o |=> !st.first) else $error("pointer flag stuck");
  AST_WR_PULSE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_valid_o |=> !wr_valid_o) else $error("write strobe too long");
  AST_ACK_END: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(sda_oe_o) |-> ##[1:900] !sda_oe_o) else $error("ack never released");

  COV_OWN_ACK: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(sda_oe_o) && !st.bcast);
  COV_BCAST_WR: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_valid_o && wr_bcast_o);
  COV_TIMEOUT: cover property (@(posedge mclk_i) disable iff (sys_rst_i) timeout_o);
  COV_RESTART: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    st.state == addr_sel_pkg::ST_DATA ##1 st.state == addr_sel_pkg::ST_ADDR);

endmodule

// File: rtl/pin_sync.sv
// Three-stage synchroniser with agreement check for pin inputs.
`timescale 1ns/1ns
module pin_sync (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A change counts only when the second and third stages agree.
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= 4'hF;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.lvl;

endmodule

// File: test/i2c_master_model.sv
// Two-wire bus controller model that clocks the target under test.
`timescale 1ns/1ns
module i2c_master_model (
  input  wire logic mclk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Data moves only in the low half, well after the target's synced fall.
  task automatic send_bit(input logic v, output logic r);
    wait_clk(5);
    sda_oe_o <= ~v;
    wait_clk(5);
    scl_o <= 1'b1;
    wait_clk(4);
    r = sda_line_i;
    wait_clk(4);
    scl_o <= 1'b0;
  endtask
  task automatic start();
    wait_clk(8);
    sda_oe_o <= 1'b1;
    wait_clk(8);
    scl_o <= 1'b0;
  endtask
  // Repeated start from the low clock phase that follows an acknowledge bit.
  task automatic restart();
    wait_clk(5);
    sda_oe_o <= 1'b0;
    wait_clk(5);
    scl_o <= 1'b1;
    wait_clk(8);
    sda_oe_o <= 1'b1;
    wait_clk(8);
    scl_o <= 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) send_bit(b[i], r);
    send_bit(1'b1, ack);
  endtask
  task automatic stop();
    wait_clk(5);
    sda_oe_o <= 1'b1;
    wait_clk(5);
    scl_o <= 1'b1;
    wait_clk(8);
    sda_oe_o <= 1'b0;
    wait_clk(8);
  endtask
  task automatic hold_low(input int n);
    wait_clk(8);
    sda_oe_o <= 1'b1;
    wait_clk(n);
    sda_oe_o <= 1'b0;
    wait_clk(8);
  endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the two-wire target address block.
`timescale 1ns/1ns
module testbench;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  sel_code_i = 8'h00;
  logic        scl, m_oe, sda_line, sda_o, sda_oe_o, ack;
  logic        wr_valid_o, wr_first_o, wr_bcast_o, timeout_o;
  logic [6:0]  own_addr_o;
  logic [7:0]  status_o, wr_data_o;
  logic [9:0]  exp_q[$];
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_to = 0;
  int          cyc = 0;
  int unsigned k;

  always #10 mclk_i = ~mclk_i;
  // Open-drain wire with pull-up: released means high.
  assign sda_line = (m_oe || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;

  i2c_master_model u_master (.mclk_i(mclk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_oe_o(m_oe));
  i2c_target_addr #(.TLOW_CYCLES(200)) u_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line),
    .sel_code_i(sel_code_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .own_addr_o(own_addr_o),
    .status_o(status_o), .wr_valid_o(wr_valid_o), .wr_first_o(wr_first_o),
    .wr_bcast_o(wr_bcast_o), .wr_data_o(wr_data_o), .timeout_o(timeout_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // The address is caught once after reset, so each select level needs a reset.
  task automatic do_reset(input logic [7:0] code);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    sel_code_i <= code;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
  endtask
  // Data bytes keep a set bit so no byte alone trips the stuck-low limit.
  task automatic frame(input logic [6:0] a, input logic rw, input int nb, input logic ak);
    logic [7:0] d;
    u_master.start();
    u_master.send_byte({a, rw}, ack);
    check({9'h0, ack}, {9'h0, ~ak});
    for (int i = 0; i < nb; i++) begin
      d = 8'($urandom) | 8'h11;
      if (ak) exp_q.push_back({i == 0, a == 7'h58, d});
      u_master.send_byte(d, ack);
      check({9'h0, ack}, {9'h0, ~ak});
    end
    u_master.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    cyc++;
    if (timeout_o === 1'b1) n_to++;
    if (wr_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(10'h3ff, 10'h000);
      else check({wr_first_o, wr_bcast_o, wr_data_o}, exp_q.pop_front());
    end
    if (cyc > 60000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(22));
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      k = 6 + $urandom_range(19);
      do_reset(8'(b * 32 + k));
      check({3'h0, own_addr_o}, {3'h0, 7'h50 + 7'(b)});
      check({2'h0, status_o}, 10'h000);
      // Only edges between two bands warn; the outer ends of the range never do.
      do_reset(8'(b * 32 + 1));
      check({3'h0, own_addr_o}, {3'h0, 7'h50 + 7'(b)});
      check({2'h0, status_o}, (b > 0) ? 10'h020 : 10'h000);
      do_reset(8'(b * 32 + 30));
      check({3'h0, own_addr_o}, {3'h0, 7'h50 + 7'(b)});
      check({2'h0, status_o}, (b < 7) ? 10'h020 : 10'h000);
    end
    do_reset(8'h00);
    check({3'h0, own_addr_o}, 10'h050);
    check({2'h0, status_o}, 10'h000);
    do_reset(8'hff);
    check({3'h0, own_addr_o}, 10'h057);
    check({2'h0, status_o}, 10'h000);
    do_reset(8'h6a);
    frame(7'h53, 1'b0, 3, 1'b1);
    frame(7'h58, 1'b0, 2, 1'b1);
    // Deliberate misuse: a broadcast read must be left unanswered.
    frame(7'h58, 1'b1, 0, 1'b0);
    frame(7'h53, 1'b1, 0, 1'b1);
    // A repeated start inside a write must bring back the pointer byte.
    u_master.start();
    u_master.send_byte(8'ha6, ack);
    check({9'h0, ack}, 10'h000);
    exp_q.push_back({2'b10, 8'h3c});
    u_master.send_byte(8'h3c, ack);
    check({9'h0, ack}, 10'h000);
    u_master.restart();
    u_master.send_byte(8'ha6, ack);
    check({9'h0, ack}, 10'h000);
    exp_q.push_back({2'b10, 8'h5d});
    u_master.send_byte(8'h5d, ack);
    check({9'h0, ack}, 10'h000);
    u_master.stop();
    frame(7'h52, 1'b0, 1, 1'b0);
    u_master.hold_low(300);
    check(10'(n_to), 10'h001);
    frame(7'h53, 1'b0, 1, 1'b1);
    check(10'(exp_q.size()), 10'h000);
    finish_test();
  end
endmodule
